/* File: rtl/opd_pkg.sv */
// Package of constants and types for the panel setup command decoder.
// Functional notes
// - A8H mode byte, next byte sets ratio.
// - Ratio uses low six bits plus one.
// - ADH then 8AH/8BH; bit0 enables converter.
// - Supply mode follows display and converter flags.
// - AEH/AFH: bit0 selects display off/on.
// - Display off halts oscillator, converter, drivers.
// - Sleep keeps settings and accepts memory writes.
// - B0H-B7H load page, display unaffected.
// - Cx bit3 selects common scan direction.
// - D3H then offset from six low bits.
// - Offset k shifts image, wraps modulo 64.
// - D5H then low nibble plus one divides.
// - High nibble trims oscillator in 5% steps.
// - Frame rate from oscillator, divider, rows, ratio.
// - Busy flag high rejects commands.
package opd_pkg;

   // Command byte codes.
   localparam logic [7:0] CMD_MUX_MODE = 8'ha8;
   localparam logic [7:0] CMD_CONV_MODE = 8'had;
   localparam logic [7:0] CMD_OFS_MODE = 8'hd3;
   localparam logic [7:0] CMD_CLK_MODE = 8'hd5;
   localparam logic [6:0] CMD_DISP_HI = 7'h57;
   localparam logic [4:0] CMD_PAGE_HI = 5'h16;
   localparam logic [3:0] CMD_SCAN_HI = 4'hc;

   // Field positions inside command, parameter and status bytes.
   localparam int SCAN_BIT = 3;
   localparam int CONV_BIT = 0;
   localparam int DISP_BIT = 0;
   localparam int STATUS_BUSY_BIT = 7;
   localparam int STATUS_OFF_BIT = 6;

   // Power-on values of the settings.
   localparam logic [5:0] RST_MUX_M1 = 6'h3f;
   localparam logic RST_CONV_EN = 1'b1;
   localparam logic [5:0] RST_OFFSET = 6'h00;
   localparam logic [3:0] RST_DIV_M1 = 4'h0;
   localparam logic [3:0] RST_TRIM = 4'h5;
   localparam logic [2:0] RST_PAGE = 3'h0;

   // Oscillator model: nominal rate is the clock over OSC_NOM_DIV.
   // Trim code c scales the rate by (15 + c) / 20.
   localparam logic [4:0] OSC_BASE_INC = 5'h0f;
   localparam logic [6:0] OSC_NOM_DIV = 7'h04;
   localparam logic [6:0] OSC_LIMIT = 7'h50;

   // Display clocks spent on each common row, less one.
   localparam logic [1:0] ROW_CLKS_M1 = 2'h3;

   // Busy time after reset, in ns, and the cycles at 40 MHz.
   localparam int CLK_PERIOD_PS = 25000;
   localparam int BUSY_RST_NS = 1000;
   localparam int BUSY_RST_CYC =
      (BUSY_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] BUSY_RST_LOAD = 8'(BUSY_RST_CYC);

   // Decoder states.
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_MUX_ARG = 3'b001,
      ST_CONV_ARG = 3'b010,
      ST_OFS_ARG = 3'b011,
      ST_CLK_ARG = 3'b100
   } opd_state_e;

   // All operating settings travel together.
   typedef struct packed {
      logic [5:0] mux_m1;
      logic conv_en;
      logic disp_on;
      logic [2:0] page;
      logic scan_down;
      logic [5:0] offset;
      logic [3:0] div_m1;
      logic [3:0] trim;
   } opd_cfg_s;

   localparam opd_cfg_s RST_CFG = '{
      mux_m1: RST_MUX_M1, conv_en: RST_CONV_EN, disp_on: 1'b0,
      page: RST_PAGE, scan_down: 1'b0, offset: RST_OFFSET,
      div_m1: RST_DIV_M1, trim: RST_TRIM};

endpackage

/* File: rtl/opd_osc.sv */
// Trimmed oscillator model and display row clock divider.
`timescale 1ns/1ps
module opd_osc (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [3:0] trim_i,
   input wire logic [3:0] div_m1_i,
   output logic display_row_clock_en_o
);

   logic [6:0] acc_q, acc_d; // Phase accumulator of the oscillator.
   logic [3:0] div_q, div_d; // Divider count of oscillator ticks.
   logic display_row_clock_d; // Next display clock enable.
   logic [6:0] sum; // Accumulator plus trimmed step.

   // The step grows with the trim code, so the tick rate follows it.
   // Stopping run_i clears the phase: a halted oscillator restarts clean.
   always_comb begin
      sum = acc_q + 7'(opd_pkg::OSC_BASE_INC + 5'(trim_i));
      acc_d = acc_q;
      div_d = div_q;
      display_row_clock_d = 1'b0;
      if (!run_i) begin
         acc_d = 7'h00;
         div_d = 4'h0;
      end else if (sum >= opd_pkg::OSC_LIMIT) begin
         acc_d = sum - opd_pkg::OSC_LIMIT;
         // One oscillator tick; divide by div_m1 + 1.
         if (div_q >= div_m1_i) begin
            div_d = 4'h0;
            display_row_clock_d = 1'b1;
         end else begin
            div_d = div_q + 4'h1;
         end
      end else begin
         acc_d = sum;
      end
   end

   // State registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_q <= 7'h00;
         div_q <= 4'h0;
         display_row_clock_en_o <= 1'b0;
      end else begin
         acc_q <= acc_d;
         div_q <= div_d;
         display_row_clock_en_o <= display_row_clock_d;
      end
   end

endmodule

/* File: rtl/opd_scan.sv */
// Common row sequencer: counts display clocks per row and rows per frame.
`timescale 1ns/1ps
module opd_scan (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic display_row_clock_en_i,
   input wire logic [5:0] mux_m1_i,
   output logic [5:0] row_idx_o,
   output logic row_tick_o,
   output logic frame_tick_o
);

   logic [1:0] clk_q, clk_d; // Display clocks spent on this row.
   logic [5:0] idx_d; // Next row index.
   logic row_d; // Next row pulse.
   logic frame_d; // Next frame pulse.

   // Frame length is (mux_m1 + 1) rows of ROW_CLKS_M1 + 1 clocks each.
   // The >= compare wraps at the end of the current row if the ratio shrinks mid frame.
   always_comb begin
      clk_d = clk_q;
      idx_d = row_idx_o;
      row_d = 1'b0;
      frame_d = 1'b0;
      if (!run_i) begin
         clk_d = 2'h0;
         idx_d = 6'h00;
      end else if (display_row_clock_en_i) begin
         if (clk_q == opd_pkg::ROW_CLKS_M1) begin
            clk_d = 2'h0;
            row_d = 1'b1;
            if (row_idx_o >= mux_m1_i) begin
               idx_d = 6'h00;
               frame_d = 1'b1;
            end else begin
               idx_d = row_idx_o + 6'h01;
            end
         end else begin
            clk_d = clk_q + 2'h1;
         end
      end
   end

   // State registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         clk_q <= 2'h0;
         row_idx_o <= 6'h00;
         row_tick_o <= 1'b0;
         frame_tick_o <= 1'b0;
      end else begin
         clk_q <= clk_d;
         row_idx_o <= idx_d;
         row_tick_o <= row_d;
         frame_tick_o <= frame_d;
      end
   end

endmodule

/* File: rtl/opd_decoder.sv */
// Panel setup command decoder with sleep control and row scan outputs.
`timescale 1ns/1ps
module opd_decoder (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_data_select_i,
   input wire logic [7:0] cmd_byte_i,
   output logic busy_o,
   output logic [7:0] status_o,
   output logic reject_o,
   output logic mem_wr_o,
   output logic [7:0] mem_data_o,
   output logic [2:0] page_o,
   output logic [6:0] mux_count_o,
   output logic conv_en_o,
   output logic display_on_o,
   output logic sleep_o,
   output logic conv_run_o,
   output logic ext_supply_o,
   output logic osc_run_o,
   output logic drive_en_o,
   output logic scan_down_o,
   output logic [5:0] offset_o,
   output logic [4:0] div_ratio_o,
   output logic [3:0] osc_trim_o,
   output logic display_row_clock_o,
   output logic [5:0] common_row_output_o,
   output logic [5:0] scan_line_o,
   output logic frame_o
);

   // Decoder state and settings.
   opd_pkg::opd_state_e st_q, st_d;
   opd_pkg::opd_cfg_s cfg_q, cfg_d;
   logic [7:0] busy_cnt_q, busy_cnt_d; // Cycles left of reset busy.
   logic busy_q, busy_d; // Busy flag as seen by the host.
   logic take; // A host byte is accepted this cycle.
   logic take_cmd; // The accepted byte is a command byte.
   logic rej_d; // Next reject pulse.
   logic wr_d; // Next memory write pulse.
   logic [7:0] wdata_d; // Next memory write data.
   logic run; // Oscillator and scan enable.
   logic display_row_clock_en; // Display clock enable from the divider.
   logic [5:0] row_idx; // Row position inside the frame.
   logic row_tick; // Row advance pulse.
   logic frame_tick; // Frame end pulse.
   logic [5:0] com_d; // Next common row driven.

   // Parameter state for a two-byte mode code, ST_CMD for any other byte.
   function automatic opd_pkg::opd_state_e mode_of(input logic [7:0] b);
      mode_of = opd_pkg::ST_CMD;
      case (b)
         opd_pkg::CMD_MUX_MODE: mode_of = opd_pkg::ST_MUX_ARG;
         opd_pkg::CMD_CONV_MODE: mode_of = opd_pkg::ST_CONV_ARG;
         opd_pkg::CMD_OFS_MODE: mode_of = opd_pkg::ST_OFS_ARG;
         opd_pkg::CMD_CLK_MODE: mode_of = opd_pkg::ST_CLK_ARG;
         default: mode_of = opd_pkg::ST_CMD;
      endcase
   endfunction

   // A byte counts only when it is offered while the busy flag is low.
   assign take = cmd_valid_i && !busy_q;
   assign take_cmd = take && !cmd_data_select_i;

   // Command interpretation. Codes outside the set are simply ignored,
   // which is the quietest answer to an undefined byte.
   always_comb begin
      st_d = st_q;
      cfg_d = cfg_q;
      if (take_cmd) begin
         case (st_q)
            opd_pkg::ST_CMD: begin
               st_d = mode_of(cmd_byte_i);
               if (cmd_byte_i[7:1] == opd_pkg::CMD_DISP_HI) begin
                  cfg_d.disp_on = cmd_byte_i[opd_pkg::DISP_BIT];
               end else if (cmd_byte_i[7:3] == opd_pkg::CMD_PAGE_HI) begin
                  cfg_d.page = cmd_byte_i[2:0];
               end else if (cmd_byte_i[7:4] == opd_pkg::CMD_SCAN_HI) begin
                  cfg_d.scan_down = cmd_byte_i[opd_pkg::SCAN_BIT];
               end
            end
            // The byte after a mode byte is a parameter, whatever its value.
            opd_pkg::ST_MUX_ARG: begin
               cfg_d.mux_m1 = cmd_byte_i[5:0];
               st_d = opd_pkg::ST_CMD;
            end
            opd_pkg::ST_CONV_ARG: begin
               // Taken at any time; the host keeps the display off.
               cfg_d.conv_en = cmd_byte_i[opd_pkg::CONV_BIT];
               st_d = opd_pkg::ST_CMD;
            end
            opd_pkg::ST_OFS_ARG: begin
               cfg_d.offset = cmd_byte_i[5:0];
               st_d = opd_pkg::ST_CMD;
            end
            opd_pkg::ST_CLK_ARG: begin
               cfg_d.div_m1 = cmd_byte_i[3:0];
               cfg_d.trim = cmd_byte_i[7:4];
               st_d = opd_pkg::ST_CMD;
            end
            default: st_d = opd_pkg::ST_CMD;
         endcase
      end
   end

   // Decoder registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_q <= opd_pkg::ST_CMD;
         cfg_q <= opd_pkg::RST_CFG;
      end else begin
         st_q <= st_d;
         cfg_q <= cfg_d;
      end
   end

   // Busy runs for a fixed time after reset; host bytes are refused then.
   always_comb begin
      busy_cnt_d = busy_cnt_q;
      if (busy_cnt_q != 8'h00) begin
         busy_cnt_d = busy_cnt_q - 8'h01;
      end
      busy_d = (busy_cnt_d != 8'h00);
      // Data bytes are refused too: the host watches one flag for both.
      rej_d = cmd_valid_i && busy_q;
      // Memory writes pass in sleep too; only busy stops them.
      wr_d = take && cmd_data_select_i;
      wdata_d = wr_d ? cmd_byte_i : mem_data_o;
   end

   // Busy and host side registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_cnt_q <= opd_pkg::BUSY_RST_LOAD;
         busy_q <= 1'b1;
         reject_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_data_o <= 8'h00;
      end else begin
         busy_cnt_q <= busy_cnt_d;
         busy_q <= busy_d;
         reject_o <= rej_d;
         mem_wr_o <= wr_d;
         mem_data_o <= wdata_d;
      end
   end

   assign busy_o = busy_q;

   // Oscillator and scan run only with the display on.
   // Busy holds them as well, so the first frame starts from a clean phase.
   assign run = cfg_q.disp_on && !busy_q;

   opd_osc u_osc (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .trim_i(cfg_q.trim),
      .div_m1_i(cfg_q.div_m1),
      .display_row_clock_en_o(display_row_clock_en)
   );

   opd_scan u_scan (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .display_row_clock_en_i(display_row_clock_en),
      .mux_m1_i(cfg_q.mux_m1),
      .row_idx_o(row_idx),
      .row_tick_o(row_tick),
      .frame_tick_o(frame_tick)
   );

   // Direction applies at once; a downward scan walks from the last row.
   always_comb begin
      com_d = cfg_q.scan_down ? (cfg_q.mux_m1 - row_idx) : row_idx;
   end

   // Output registers. Every output is a flop, one cycle behind settings.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         status_o <= 8'h00;
         page_o <= opd_pkg::RST_PAGE;
         mux_count_o <= 7'h00;
         conv_en_o <= opd_pkg::RST_CONV_EN;
         display_on_o <= 1'b0;
         sleep_o <= 1'b1;
         conv_run_o <= 1'b0;
         ext_supply_o <= 1'b0;
         osc_run_o <= 1'b0;
         drive_en_o <= 1'b0;
         scan_down_o <= 1'b0;
         offset_o <= opd_pkg::RST_OFFSET;
         div_ratio_o <= 5'h00;
         osc_trim_o <= opd_pkg::RST_TRIM;
         display_row_clock_o <= 1'b0;
         common_row_output_o <= 6'h00;
         scan_line_o <= 6'h00;
         frame_o <= 1'b0;
      end else begin
         // Status byte: busy on top, display off just below, rest zero.
         status_o <= 8'h00;
         status_o[opd_pkg::STATUS_BUSY_BIT] <= busy_q;
         status_o[opd_pkg::STATUS_OFF_BIT] <= !cfg_q.disp_on;
         page_o <= cfg_q.page;
         mux_count_o <= 7'(cfg_q.mux_m1) + 7'h01;
         conv_en_o <= cfg_q.conv_en;
         display_on_o <= cfg_q.disp_on;
         sleep_o <= !cfg_q.disp_on;
         conv_run_o <= cfg_q.disp_on && cfg_q.conv_en;
         ext_supply_o <= cfg_q.disp_on && !cfg_q.conv_en;
         osc_run_o <= run;
         drive_en_o <= run;
         scan_down_o <= cfg_q.scan_down;
         offset_o <= cfg_q.offset;
         div_ratio_o <= 5'(cfg_q.div_m1) + 5'h01;
         osc_trim_o <= cfg_q.trim;
         display_row_clock_o <= row_tick;
         common_row_output_o <= com_d;
         // Row c shows line c + k, so the image moves k rows up, mod 64.
         scan_line_o <= com_d + cfg_q.offset;
         frame_o <= frame_tick;
      end
   end

   // Checks on the decoder.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   AST_MUX_MODE: assert property (
      take_cmd && st_q == opd_pkg::ST_CMD
      && cmd_byte_i == opd_pkg::CMD_MUX_MODE
      |=> st_q == opd_pkg::ST_MUX_ARG)
      else $error("mux mode byte did not arm parameter");
   AST_MUX_COUNT: assert property (
      take_cmd && st_q == opd_pkg::ST_MUX_ARG
      |=> ##1 mux_count_o == 7'($past(cmd_byte_i[5:0], 2)) + 7'h01)
      else $error("mux count wrong after parameter");
   AST_CONV_SET: assert property (
      take_cmd && st_q == opd_pkg::ST_CONV_ARG
      |=> ##1 conv_en_o == $past(cmd_byte_i[0], 2))
      else $error("converter enable not loaded");
   AST_SUPPLY: assert property (
      display_on_o |-> (conv_run_o == conv_en_o)
      && (ext_supply_o == !conv_en_o) && !sleep_o)
      else $error("supply mode inconsistent");
   AST_DISP: assert property (
      take_cmd && st_q == opd_pkg::ST_CMD && cmd_byte_i[7:1] == 7'h57
      |=> ##1 display_on_o == $past(cmd_byte_i[0], 2))
      else $error("display on/off not applied");
   AST_SLEEP: assert property (
      !display_on_o |-> !osc_run_o && !drive_en_o && !conv_run_o)
      else $error("sleep left something running");
   AST_SLEEP_WRITE: assert property (
      take && cmd_data_select_i |=> mem_wr_o
      && mem_data_o == $past(cmd_byte_i) && $stable(cfg_q))
      else $error("memory write lost or changed settings");
   AST_PAGE: assert property (
      take_cmd && st_q == opd_pkg::ST_CMD && cmd_byte_i[7:3] == 5'h16
      |=> cfg_q.page == $past(cmd_byte_i[2:0])
      && cfg_q.offset == $past(cfg_q.offset)
      && cfg_q.scan_down == $past(cfg_q.scan_down))
      else $error("page load wrong or touched display");
   AST_OFFSET: assert property (
      take_cmd && st_q == opd_pkg::ST_OFS_ARG
      |=> cfg_q.offset == $past(cmd_byte_i[5:0]))
      else $error("offset not loaded");
   AST_CLKSET: assert property (
      take_cmd && st_q == opd_pkg::ST_CLK_ARG
      |=> ##1 osc_trim_o == $past(cmd_byte_i[7:4], 2)
      && div_ratio_o == 5'($past(cmd_byte_i[3:0], 2)) + 5'h01)
      else $error("clock setting not loaded");
   AST_BUSY: assert property (
      cmd_valid_i && busy_q |=> reject_o && $stable(cfg_q)
      && $stable(st_q) && !mem_wr_o)
      else $error("byte taken while busy");
   AST_PARAM: assert property (
      take_cmd && st_q != opd_pkg::ST_CMD |=> st_q == opd_pkg::ST_CMD)
      else $error("parameter byte not consumed");

   // A new frame starts on the first row of the chosen direction.
   AST_SCAN_START: assert property (
      frame_o |-> common_row_output_o
      == (scan_down_o ? 6'(mux_count_o - 7'h01) : 6'h00))
      else $error("frame did not start on first scanned row");
   // The shown line is the driven row moved by the offset, mod 64.
   AST_SCAN_LINE: assert property (
      scan_line_o == 6'(common_row_output_o + offset_o))
      else $error("shown line not row plus offset");
   // A frame ends only where a row ends.
   AST_FRAME_ROW: assert property (
      frame_o |-> display_row_clock_o)
      else $error("frame pulse without row pulse");

   // Main scenarios that the bench is expected to reach.
   COV_DISPLAY_ON: cover property (display_on_o && display_row_clock_o);
   COV_FRAME: cover property (frame_o);
   COV_OFFSET: cover property (take_cmd && st_q == opd_pkg::ST_OFS_ARG);
   COV_SLEEP_WRITE: cover property (mem_wr_o && sleep_o);
   COV_SCAN_DOWN: cover property (frame_o && scan_down_o);

endmodule

/* File: verification/opd_host.sv */
// Host model that issues command and display data bytes to the decoder.
`timescale 1ns/1ps
module opd_host (
   input wire logic ref_clk_i,
   input wire logic busy_i,
   output logic cmd_valid_o,
   output logic cmd_data_select_o,
   output logic [7:0] cmd_byte_o,
   output logic stall_o
);
   // Lines start idle; stall flags a busy wait that never ended.
   initial begin
      cmd_valid_o = 1'b0;
      cmd_data_select_o = 1'b0;
      cmd_byte_o = 8'h00;
      stall_o = 1'b0;
   end

   // Sends one byte, entered just after a rising edge.
   // The byte is held through the edge that takes it.
   task automatic send(input logic sel, input logic [7:0] b,
                       input logic wait_busy);
      int n;
      n = 0;
      while (wait_busy && busy_i !== 1'b0 && n < 200) begin
         cmd_valid_o = 1'b0;
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      if (n >= 200) begin
         stall_o = 1'b1;
      end
      cmd_valid_o = 1'b1;
      cmd_data_select_o = sel;
      cmd_byte_o = b;
      @(posedge ref_clk_i);
      #1;
   endtask

   // Mode byte then its parameter, back to back.
   task automatic cmd2(input logic [7:0] mode, input logic [7:0] arg);
      send(1'b0, mode, 1'b1);
      send(1'b0, arg, 1'b1);
   endtask

   // Released lines change every cycle so a stale byte never looks valid.
   task automatic idle(input int cycles);
      repeat (cycles) begin
         cmd_valid_o = 1'b0;
         cmd_data_select_o = ~cmd_data_select_o;
         cmd_byte_o = ~cmd_byte_o;
         @(posedge ref_clk_i);
         #1;
      end
   endtask
endmodule

/* File: verification/test_opd_decoder.sv */
// Self-checking bench for the panel setup command decoder.
`timescale 1ns/1ps
module test_opd_decoder;
   logic ref_clk = 1'b0; // Runs at 40 MHz.
   logic rst = 1'b1; // Synchronous reset, active high.
   logic valid, sel, busy, reject, mem_wr, conv_en, disp_on, sleep;
   logic conv_run, ext_sup, osc_run, drive_en, scan_down, row_clk;
   logic frame, stall;
   logic [7:0] byte_v, status, mem_data;
   logic [2:0] page;
   logic [6:0] mux_count;
   logic [5:0] offset, com_row, scan_line;
   logic [4:0] div_ratio;
   logic [3:0] trim;
   logic [7:0] scan_codes [4] = '{8'hc8, 8'hc0, 8'hcf, 8'hc7};
   int error_cnt = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.
   int n;
   int rows; // Row pulses seen in the last frame.

   // Half period of 12.5 ns gives the 25 ns clock.
   always #12.5 ref_clk = ~ref_clk;

   opd_host u_host (
      .ref_clk_i(ref_clk),
      .busy_i(busy),
      .cmd_valid_o(valid),
      .cmd_data_select_o(sel),
      .cmd_byte_o(byte_v),
      .stall_o(stall)
   );

   opd_decoder u_dut (
      .ref_clk_i(ref_clk),
      .rst_i(rst),
      .cmd_valid_i(valid),
      .cmd_data_select_i(sel),
      .cmd_byte_i(byte_v),
      .busy_o(busy),
      .status_o(status),
      .reject_o(reject),
      .mem_wr_o(mem_wr),
      .mem_data_o(mem_data),
      .page_o(page),
      .mux_count_o(mux_count),
      .conv_en_o(conv_en),
      .display_on_o(disp_on),
      .sleep_o(sleep),
      .conv_run_o(conv_run),
      .ext_supply_o(ext_sup),
      .osc_run_o(osc_run),
      .drive_en_o(drive_en),
      .scan_down_o(scan_down),
      .offset_o(offset),
      .div_ratio_o(div_ratio),
      .osc_trim_o(trim),
      .display_row_clock_o(row_clk),
      .common_row_output_o(com_row),
      .scan_line_o(scan_line),
      .frame_o(frame)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One command byte, waiting for busy to clear first.
   task automatic cmd(input logic [7:0] b);
      u_host.send(1'b0, b, 1'b1);
   endtask

   // Waits for the frame pulse and counts the row pulses up to it;
   // meanwhile the shown line must be row plus offset, wrapped in six bits.
   task automatic wait_frame(output int cyc, output int rows);
      logic [5:0] exp_line;
      cyc = 0;
      rows = 0;
      while (frame !== 1'b1 && cyc < 2000) begin
         exp_line = com_row + offset;
         check({2'b00, scan_line}, {2'b00, exp_line});
         if (row_clk === 1'b1) begin
            rows++;
         end
         u_host.idle(1);
         cyc++;
      end
      // The last row of a frame pulses together with the frame.
      if (row_clk === 1'b1) begin
         rows++;
      end
      if (cyc >= 2000) begin
         error_cnt++;
         test_done();
      end
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      u_host.idle(2);
      // A byte offered while busy is refused and changes nothing.
      u_host.send(1'b0, 8'haf, 1'b0);
      check(reject, 8'h01);
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         u_host.idle(1);
         n++;
      end
      if (n >= 100) begin
         error_cnt++;
         test_done();
      end
      u_host.idle(2);
      check(disp_on, 8'h00);
      check(status, 8'h40);
      check(sleep, 8'h01);
      check({1'b0, mux_count}, 8'd64);
      check(conv_en, 8'h01);
      check(osc_run, 8'h00);
      check(drive_en, 8'h00);
      check(offset, 8'h00);
      check(div_ratio, 8'h01);
      check(trim, 8'h05);
      check(scan_down, 8'h00);
      check(page, 8'h00);
      // Ratio keeps six low bits plus one.
      u_host.cmd2(8'ha8, 8'hc5);
      u_host.idle(2);
      check({1'b0, mux_count}, 8'd6);
      u_host.cmd2(8'ha8, 8'h00);
      u_host.idle(2);
      check({1'b0, mux_count}, 8'd1);
      // A parameter that looks like display on is still a parameter.
      u_host.cmd2(8'hd3, 8'haf);
      u_host.idle(2);
      check(offset, 8'h2f);
      check(disp_on, 8'h00);
      u_host.cmd2(8'hd3, 8'h70);
      u_host.idle(2);
      check(offset, 8'h30);
      // Divider and trim at both ends, then back to defaults.
      u_host.cmd2(8'hd5, 8'hff);
      u_host.idle(2);
      check(div_ratio, 8'd16);
      check(trim, 8'h0f);
      u_host.cmd2(8'hd5, 8'h00);
      u_host.idle(2);
      check(div_ratio, 8'd1);
      check(trim, 8'h00);
      u_host.cmd2(8'hd5, 8'h50);
      // Converter off then on, with a data write between mode and value.
      // Display is off here, as the host must ensure.
      u_host.cmd2(8'had, 8'h8a);
      u_host.idle(2);
      check(conv_en, 8'h00);
      cmd(8'had);
      u_host.send(1'b1, 8'h5a, 1'b1);
      check(mem_wr, 8'h01);
      check(mem_data, 8'h5a);
      cmd(8'h8b);
      u_host.idle(2);
      check(conv_en, 8'h01);
      for (int i = 0; i < 8; i++) begin
         cmd(8'hb0 | 8'(i));
         u_host.idle(2);
         check(page, 8'(i));
      end
      foreach (scan_codes[i]) begin
         cmd(scan_codes[i]);
         u_host.idle(2);
         check(scan_down, {7'h00, scan_codes[i][3]});
      end
      // Four rows, display on with the converter enabled.
      u_host.cmd2(8'ha8, 8'h03);
      cmd(8'haf);
      u_host.idle(2);
      check(disp_on, 8'h01);
      check(sleep, 8'h00);
      check(conv_run, 8'h01);
      check(ext_sup, 8'h00);
      check(osc_run, 8'h01);
      check(drive_en, 8'h01);
      check(status, 8'h00);
      // Nominal: tick per 4 cycles, 4 per row, 4 rows gives 64.
      wait_frame(n, rows);
      check({2'b00, com_row}, 8'h00);
      u_host.idle(1);
      wait_frame(n, rows);
      check(8'(n + 1), 8'd64);
      check(8'(rows), 8'd4);
      // Downward scan: the next frame starts on the last active row.
      cmd(8'hc8);
      wait_frame(n, rows);
      check({2'b00, com_row}, 8'h03);
      // Display on with the converter disabled needs outside supply.
      cmd(8'hae);
      u_host.cmd2(8'had, 8'h8a);
      cmd(8'haf);
      u_host.idle(2);
      check(ext_sup, 8'h01);
      check(conv_run, 8'h00);
      // Sleep keeps settings and still takes memory writes.
      cmd(8'hae);
      u_host.idle(2);
      check(sleep, 8'h01);
      check(osc_run, 8'h00);
      check(drive_en, 8'h00);
      check(ext_sup, 8'h00);
      check({1'b0, mux_count}, 8'd4);
      check(offset, 8'h30);
      u_host.send(1'b1, 8'hc3, 1'b1);
      check(mem_wr, 8'h01);
      check(mem_data, 8'hc3);
      u_host.idle(2);
      check(stall, 8'h00);
      test_done();
   end
endmodule
